// ===== include/pdbmc_cc_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// cc wire shared by both ends
// ----------------------------------------------------------------
interface pdbmc_cc_if;
  logic devOut;  // device drive level
  logic devOe;   // device drives the wire
  logic ptnOut;  // partner drive level
  logic ptnOe;   // partner drives the wire
  logic line;    // resolved wire level

  // undriven wire rests low
  assign line = devOe ? devOut : (ptnOe ? ptnOut : 1'h0);

  modport dev (output devOut, output devOe, input line);
  modport ptn (output ptnOut, output ptnOe, input line);
endinterface // pdbmc_cc_if

// ===== include/pdbmc_pkg.sv
// ----------------------------------------------------------------
// shared constants and types of the cc-wire bmc timing ends
// ----------------------------------------------------------------
package pdbmc_pkg;

  // ----------------------------------------------------------------
  // clock and rates
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 100000;  // mclk rate
  localparam int BIT_RATE_KBPS  = 300;     // nominal bit rate
  localparam int RXF_NS         = 100;     // shortest pulse accepted
  localparam int GAP_MIN_US     = 25;      // least inter-frame gap
  localparam int GAP_MAX_US     = 50;      // longest inter-frame gap
  localparam int HOLD_MIN_US    = 1;       // least low hold at frame end
  localparam int END_DRV_MAX_US = 23;      // release bound after frame
  localparam int FRS_MIN_US     = 60;      // fast swap pulse, least
  localparam int FRS_MAX_US     = 120;     // fast swap pulse, longest
  localparam int IDLE_US        = 5;       // silence that means idle

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  localparam logic [13:0] BIT_CYC  = 14'(CLK_KHZ / BIT_RATE_KBPS);
  localparam logic [13:0] HALF_CYC = 14'(CLK_KHZ / BIT_RATE_KBPS / 2);
  localparam logic [13:0] THR_CYC  = 14'(CLK_KHZ * 3 / BIT_RATE_KBPS / 4);
  localparam logic [13:0] FILT_CYC = 14'((RXF_NS * CLK_KHZ + 999999)
                                         / 1000000);
  localparam logic [13:0] GAP_CYC  = 14'(GAP_MIN_US * CLK_KHZ / 1000);
  localparam logic [13:0] HOLD_CYC = 14'(HOLD_MIN_US * CLK_KHZ / 1000);
  localparam logic [13:0] IDLE_CYC = 14'(IDLE_US * CLK_KHZ / 1000);
  localparam logic [13:0] FRS_CYC  = 14'((FRS_MIN_US + FRS_MAX_US) / 2
                                         * CLK_KHZ / 1000);

  // ----------------------------------------------------------------
  // framing and coding
  // ----------------------------------------------------------------
  localparam logic [6:0]  PRE_BITS  = 7'h40;         // preamble length
  localparam logic [1:0]  TRANS_MIN = 2'h3;          // edges for busy
  localparam logic [31:0] CRC_POLY  = 32'hEDB8_8320; // reflected poly
  localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF; // crc seed

  // transmit sequencer states, gray from idle through preamble, data and crc to tail
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_PRE  = 3'h1,
    TX_DATA = 3'h3,
    TX_CRC  = 3'h2,
    TX_TAIL = 3'h6,
    TX_FRS  = 3'h4
  } pdbmc_tx_st_t;

  // whole state of the device end
  typedef struct packed {
    pdbmc_tx_st_t st;      // transmit state
    logic [13:0]  cnt;     // bit, hold or swap pulse timer
    logic [13:0]  gap;     // cycles since last frame end
    logic [5:0]   bitCnt;  // bit index in phase
    logic [7:0]   sh;      // byte being sent
    logic         last;    // byte is the final one
    logic [31:0]  crc;     // running crc
    logic         lvl;     // driven line level
    logic         oe;      // line drive enable
    logic         s1;      // sync stage 1
    logic         s2;      // sync stage 2
    logic         s3;      // sync stage 3
    logic         f;       // filtered line level
    logic [3:0]   fcnt;    // filter agreement count
    logic [9:0]   ivl;     // cycles since last edge
    logic [1:0]   tcnt;    // edges seen since idle
    logic         busy;    // line non-idle
    logic         half;    // first half of a one seen
    logic         rxBit;   // recovered bit
    logic         rxVal;   // recovered bit strobe
  } pdbmc_dev_t;

  // whole state of the partner end
  typedef struct packed {
    pdbmc_tx_st_t st;      // transmit state
    logic [13:0]  cnt;     // bit or hold timer
    logic [13:0]  gap;     // cycles since last frame end
    logic [5:0]   bitCnt;  // bit index in phase
    logic [7:0]   sh;      // byte being sent
    logic         last;    // byte is the final one
    logic         lvl;     // driven line level
    logic         oe;      // line drive enable
    logic         s1;      // sync stage 1
    logic         s2;      // sync stage 2
    logic         s3;      // sync stage 3
    logic         f;       // accepted line level
    logic [9:0]   ivl;     // cycles since last edge
    logic         prim;    // a reference edge exists
    logic         half;    // first half of a one seen
    logic         rxBit;   // recovered bit
    logic         rxVal;   // recovered bit strobe
  } pdbmc_ptn_t;

endpackage

// ===== rtl/pdbmc_dev_end.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: biphase-mark at 300 kbit/s, ten percent tolerance
// RL2: reject line pulses shorter than 100 ns
// RL3: non-idle only after three line transitions
// RL4: inter-frame gap between 25 and 50 us
// RL5: start driving within 1 us of preamble
// RL6: release line within 23 us after frame
// RL7: hold low 1 us after final fall
// RL8: fast swap pulse lasts 60 to 120 us
// RL9: append 32-bit crc to host messages
// RL10: phy disabled while port is unattached; a detach during the tail hold still drives the line low until release
module pdbmc_dev_end #(
  parameter logic [13:0] FRS_CYC = pdbmc_pkg::FRS_CYC
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  pdbmc_cc_if.dev         cc,
  input  wire logic       attached,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txLast,
  output logic            txReady,
  input  wire logic       frsReq,
  output logic            txBusy,
  output logic            rxBusy,
  output logic            rxBit,
  output logic            rxBitVal
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  pdbmc_pkg::pdbmc_dev_t r_ff;     // registered state
  pdbmc_pkg::pdbmc_dev_t nxt_r;    // next state
  logic                  rxEdge;   // filtered level changed
  logic                  bitNow;   // value of the bit being sent
  logic                  endBit;   // last cycle of a bit cell
  logic                  midBit;   // last cycle of first half

  // one crc step, lsb-first reflected form
  function automatic logic [31:0] crcStep(input logic [31:0] c,
                                          input logic        b);
    logic [31:0] s;
    s = {1'h0, c[31:1]};
    crcStep = (c[0] ^ b) ? (s ^ pdbmc_pkg::CRC_POLY) : s;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r   = r_ff;
    txReady = 1'h0;
    rxEdge  = 1'h0;
    endBit  = (r_ff.cnt == pdbmc_pkg::BIT_CYC - 14'h1);
    midBit  = (r_ff.cnt == pdbmc_pkg::HALF_CYC - 14'h1);
    // bit value by phase
    case (r_ff.st)
      pdbmc_pkg::TX_PRE:  bitNow = r_ff.bitCnt[0];
      pdbmc_pkg::TX_DATA: bitNow = r_ff.sh[0];
      pdbmc_pkg::TX_CRC:  bitNow = ~r_ff.crc[0];
      default:            bitNow = 1'h0;
    endcase

    // three-stage synchroniser
    nxt_r.s1 = cc.line;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;

    // RL2: glitch filter
    if (r_ff.s2 == r_ff.s3 && r_ff.s3 != r_ff.f) begin
      if (r_ff.fcnt == pdbmc_pkg::FILT_CYC - 14'h1) begin
        nxt_r.f    = r_ff.s3;
        nxt_r.fcnt = 4'h0;
        rxEdge     = 1'h1;
      end else begin
        nxt_r.fcnt = r_ff.fcnt + 4'h1;
      end
    end else begin
      nxt_r.fcnt = 4'h0;
    end

    // ----------------------------------------------------------------
    // receive: idle detect and bit recovery
    // ----------------------------------------------------------------
    nxt_r.rxVal = 1'h0;
    // RL10: receiver off when unattached
    if (!attached || r_ff.oe) begin
      nxt_r.tcnt = 2'h0;
      nxt_r.busy = 1'h0;
      nxt_r.half = 1'h0;
      nxt_r.ivl  = 10'h0;
    end else if (rxEdge) begin
      nxt_r.ivl = 10'h0;
      // RL3: count edges to busy
      if (r_ff.tcnt != pdbmc_pkg::TRANS_MIN) begin
        nxt_r.tcnt = r_ff.tcnt + 2'h1;
      end
      if (r_ff.tcnt >= pdbmc_pkg::TRANS_MIN - 2'h1) begin
        nxt_r.busy = 1'h1;
      end
      // RL1: half or whole cell decode
      if (r_ff.busy) begin
        if (r_ff.ivl < pdbmc_pkg::THR_CYC) begin
          if (r_ff.half) begin
            nxt_r.rxBit = 1'h1;
            nxt_r.rxVal = 1'h1;
            nxt_r.half  = 1'h0;
          end else begin
            nxt_r.half = 1'h1;
          end
        end else begin
          nxt_r.rxBit = 1'h0;
          nxt_r.rxVal = 1'h1;
          nxt_r.half  = 1'h0;
        end
      end
    end else if (r_ff.ivl == pdbmc_pkg::IDLE_CYC) begin
      // long silence: back to idle
      nxt_r.tcnt = 2'h0;
      nxt_r.busy = 1'h0;
      nxt_r.half = 1'h0;
    end else begin
      nxt_r.ivl = r_ff.ivl + 10'h1;
    end

    // ----------------------------------------------------------------
    // transmit sequencer
    // ----------------------------------------------------------------
    // gap timer saturates at the least gap
    if (r_ff.gap != pdbmc_pkg::GAP_CYC) begin
      nxt_r.gap = r_ff.gap + 14'h1;
    end
    case (r_ff.st)
      pdbmc_pkg::TX_IDLE: begin
        nxt_r.oe  = 1'h0;
        nxt_r.lvl = 1'h0;
        // RL10: no transmit when unattached
        if (!attached) begin
          nxt_r.st = pdbmc_pkg::TX_IDLE;
        end else if (frsReq) begin
          // RL8: start fast swap low pulse
          nxt_r.st  = pdbmc_pkg::TX_FRS;
          nxt_r.oe  = 1'h1;
          nxt_r.cnt = 14'h0;
        end else if (txValid && r_ff.gap == pdbmc_pkg::GAP_CYC) begin
          // RL4: frame starts once gap passed
          // RL5: drive starts with first edge
          nxt_r.st     = pdbmc_pkg::TX_PRE;
          nxt_r.oe     = 1'h1;
          nxt_r.lvl    = 1'h1;
          nxt_r.cnt    = 14'h0;
          nxt_r.bitCnt = 6'h0;
          nxt_r.crc    = pdbmc_pkg::CRC_INIT;
        end
      end
      pdbmc_pkg::TX_FRS: begin
        // RL8: hold pulse for fixed length
        if (r_ff.cnt == FRS_CYC - 14'h1 || !attached) begin
          nxt_r.st = pdbmc_pkg::TX_IDLE;
          nxt_r.oe = 1'h0;
        end else begin
          nxt_r.cnt = r_ff.cnt + 14'h1;
        end
      end
      pdbmc_pkg::TX_TAIL: begin
        // RL7: hold low then release
        nxt_r.lvl = 1'h0;
        if (r_ff.cnt == pdbmc_pkg::HOLD_CYC - 14'h1) begin
          // RL6: release well inside bound
          nxt_r.st = pdbmc_pkg::TX_IDLE;
          nxt_r.oe = 1'h0;
        end else begin
          nxt_r.cnt = r_ff.cnt + 14'h1;
        end
      end
      default: begin
        if (!attached) begin
          // detach aborts the frame
          nxt_r.st  = pdbmc_pkg::TX_IDLE;
          nxt_r.oe  = 1'h0;
          nxt_r.gap = 14'h0;
        end else if (endBit) begin
          // RL1: edge at every cell boundary
          nxt_r.cnt    = 14'h0;
          nxt_r.lvl    = ~r_ff.lvl;
          nxt_r.bitCnt = r_ff.bitCnt + 6'h1;
          if (r_ff.st == pdbmc_pkg::TX_DATA) begin
            // RL9: fold sent bit into crc
            nxt_r.crc = crcStep(r_ff.crc, r_ff.sh[0]);
            nxt_r.sh  = {1'h0, r_ff.sh[7:1]};
          end
          if (r_ff.st == pdbmc_pkg::TX_CRC) begin
            nxt_r.crc = {1'h0, r_ff.crc[31:1]};
          end
          if ((r_ff.st == pdbmc_pkg::TX_PRE &&
               {1'h0, r_ff.bitCnt} == pdbmc_pkg::PRE_BITS - 7'h1) ||
              (r_ff.st == pdbmc_pkg::TX_DATA && r_ff.bitCnt[2:0] == 3'h7
               && !r_ff.last && txValid)) begin
            // take next message byte
            txReady      = 1'h1;
            nxt_r.st     = pdbmc_pkg::TX_DATA;
            nxt_r.sh     = txData;
            nxt_r.last   = txLast;
            nxt_r.bitCnt = 6'h0;
          end else if (r_ff.st == pdbmc_pkg::TX_DATA &&
                       r_ff.bitCnt[2:0] == 3'h7) begin
            // RL9: message done, send crc
            nxt_r.st     = pdbmc_pkg::TX_CRC;
            nxt_r.bitCnt = 6'h0;
          end else if (r_ff.st == pdbmc_pkg::TX_CRC &&
                       r_ff.bitCnt == 6'h1f) begin
            // frame end: force low, gap restarts
            nxt_r.st  = pdbmc_pkg::TX_TAIL;
            nxt_r.lvl = 1'h0;
            nxt_r.gap = 14'h0;
          end
        end else begin
          nxt_r.cnt = r_ff.cnt + 14'h1;
          // RL1: mid-cell edge for a one
          if (midBit && bitNow) begin
            nxt_r.lvl = ~r_ff.lvl;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cc.devOut = r_ff.lvl;
  assign cc.devOe  = r_ff.oe;
  assign txBusy    = (r_ff.st != pdbmc_pkg::TX_IDLE);
  assign rxBusy    = r_ff.busy;
  assign rxBit     = r_ff.rxBit;
  assign rxBitVal  = r_ff.rxVal;

endmodule // pdbmc_dev_end

// ===== rtl/pdbmc_ptn_end.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port partner end: bmc frames out, raw bits in
// ----------------------------------------------------------------
module pdbmc_ptn_end (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  pdbmc_cc_if.ptn         cc,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txLast,
  output logic            txReady,
  output logic            txBusy,
  output logic            rxBit,
  output logic            rxBitVal
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  pdbmc_pkg::pdbmc_ptn_t r_ff;     // registered state
  pdbmc_pkg::pdbmc_ptn_t nxt_r;    // next state
  logic                  rxEdge;   // accepted level changed
  logic                  bitNow;   // value of the bit being sent

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r   = r_ff;
    txReady = 1'h0;
    bitNow  = (r_ff.st == pdbmc_pkg::TX_PRE) ? r_ff.bitCnt[0] : r_ff.sh[0];
    // three-stage synchroniser, change once stages 2 and 3 agree
    nxt_r.s1 = cc.line;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    rxEdge   = (r_ff.s2 == r_ff.s3 && r_ff.s3 != r_ff.f);
    if (rxEdge) begin
      nxt_r.f = r_ff.s3;
    end

    // RL1: receive decode by edge spacing
    nxt_r.rxVal = 1'h0;
    if (r_ff.oe) begin
      nxt_r.prim = 1'h0;
      nxt_r.half = 1'h0;
      nxt_r.ivl  = 10'h0;
    end else if (rxEdge) begin
      nxt_r.ivl  = 10'h0;
      nxt_r.prim = 1'h1;
      if (r_ff.prim && r_ff.ivl < pdbmc_pkg::THR_CYC) begin
        nxt_r.half  = ~r_ff.half;
        nxt_r.rxBit = 1'h1;
        nxt_r.rxVal = r_ff.half;
      end else if (r_ff.prim) begin
        nxt_r.half  = 1'h0;
        nxt_r.rxBit = 1'h0;
        nxt_r.rxVal = 1'h1;
      end
    end else if (r_ff.ivl == pdbmc_pkg::IDLE_CYC) begin
      nxt_r.prim = 1'h0;
      nxt_r.half = 1'h0;
    end else begin
      nxt_r.ivl = r_ff.ivl + 10'h1;
    end

    // ----------------------------------------------------------------
    // transmit sequencer
    // ----------------------------------------------------------------
    if (r_ff.gap != pdbmc_pkg::GAP_CYC) begin
      nxt_r.gap = r_ff.gap + 14'h1;
    end
    case (r_ff.st)
      pdbmc_pkg::TX_IDLE: begin
        nxt_r.oe  = 1'h0;
        nxt_r.lvl = 1'h0;
        // RL4: wait out least gap
        // RL5: drive begins on first edge
        if (txValid && r_ff.gap == pdbmc_pkg::GAP_CYC) begin
          nxt_r.st     = pdbmc_pkg::TX_PRE;
          nxt_r.oe     = 1'h1;
          nxt_r.lvl    = 1'h1;
          nxt_r.cnt    = 14'h0;
          nxt_r.bitCnt = 6'h0;
        end
      end
      pdbmc_pkg::TX_TAIL: begin
        // RL7: low hold then release
        nxt_r.lvl = 1'h0;
        if (r_ff.cnt == pdbmc_pkg::HOLD_CYC - 14'h1) begin
          // RL6: release inside bound
          nxt_r.st = pdbmc_pkg::TX_IDLE;
          nxt_r.oe = 1'h0;
        end else begin
          nxt_r.cnt = r_ff.cnt + 14'h1;
        end
      end
      default: begin
        if (r_ff.cnt == pdbmc_pkg::BIT_CYC - 14'h1) begin
          // RL1: boundary edge
          nxt_r.cnt    = 14'h0;
          nxt_r.lvl    = ~r_ff.lvl;
          nxt_r.bitCnt = r_ff.bitCnt + 6'h1;
          nxt_r.sh     = {1'h0, r_ff.sh[7:1]};
          if ((r_ff.st == pdbmc_pkg::TX_PRE &&
               {1'h0, r_ff.bitCnt} == pdbmc_pkg::PRE_BITS - 7'h1) ||
              (r_ff.st == pdbmc_pkg::TX_DATA && r_ff.bitCnt[2:0] == 3'h7
               && !r_ff.last && txValid)) begin
            txReady      = 1'h1;
            nxt_r.st     = pdbmc_pkg::TX_DATA;
            nxt_r.sh     = txData;
            nxt_r.last   = txLast;
            nxt_r.bitCnt = 6'h0;
          end else if (r_ff.st == pdbmc_pkg::TX_DATA &&
                       r_ff.bitCnt[2:0] == 3'h7) begin
            nxt_r.st  = pdbmc_pkg::TX_TAIL;
            nxt_r.lvl = 1'h0;
            nxt_r.gap = 14'h0;
          end
        end else begin
          nxt_r.cnt = r_ff.cnt + 14'h1;
          // RL1: mid-cell edge for a one
          if (r_ff.cnt == pdbmc_pkg::HALF_CYC - 14'h1 && bitNow) begin
            nxt_r.lvl = ~r_ff.lvl;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cc.ptnOut = r_ff.lvl;
  assign cc.ptnOe  = r_ff.oe;
  assign txBusy    = (r_ff.st != pdbmc_pkg::TX_IDLE);
  assign rxBit     = r_ff.rxBit;
  assign rxBitVal  = r_ff.rxVal;

endmodule // pdbmc_ptn_end

// ===== test/pd_bmc_line_timing_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// both ends joined, plus a lone device fed by the bench
// ----------------------------------------------------------------
module pd_bmc_line_timing_tb;
  localparam logic [13:0] FRS = 14'h0014; // short swap pulse
  logic       mclk, arst_n, attached, frsReq, att2, frs2;
  logic       dValid, dLast, dReady, dBusy, rxBusy, dBit, dBitVal;
  logic       pValid, pLast, pReady, pBusy, pBit, pBitVal;
  logic       rxBusy2, bit2, val2;
  logic [7:0] dData, pData;
  logic       pq[$], dq[$], q2[$]; // received bit streams
  int         bad_count, compares;

  pdbmc_cc_if cc();
  pdbmc_cc_if cc2();

  pdbmc_dev_end #(.FRS_CYC(FRS)) pdbmc_dev_end_i (.mclk(mclk),
    .arst_n(arst_n), .cc(cc), .attached(attached), .txValid(dValid),
    .txData(dData), .txLast(dLast), .txReady(dReady), .frsReq(frsReq),
    .txBusy(dBusy), .rxBusy(rxBusy), .rxBit(dBit), .rxBitVal(dBitVal));
  pdbmc_ptn_end pdbmc_ptn_end_i (.mclk(mclk), .arst_n(arst_n), .cc(cc),
    .txValid(pValid), .txData(pData), .txLast(pLast), .txReady(pReady),
    .txBusy(pBusy), .rxBit(pBit), .rxBitVal(pBitVal));
  // lone device, its wire driven by the bench
  pdbmc_dev_end #(.FRS_CYC(FRS)) lone_pdbmc_dev_end_i (.mclk(mclk),
    .arst_n(arst_n), .cc(cc2), .attached(att2), .txValid(1'b0),
    .txData(8'h00), .txLast(1'b0), .txReady(), .frsReq(frs2),
    .txBusy(), .rxBusy(rxBusy2), .rxBit(bit2), .rxBitVal(val2));
  pdbmc_cc_properties #(.FRS_CYC(FRS)) pdbmc_cc_properties_i (
    .mclk(mclk), .arst_n(arst_n), .devOut(cc.devOut), .devOe(cc.devOe),
    .ptnOut(cc.ptnOut), .ptnOe(cc.ptnOe), .line(cc.line));

  always #5 mclk = ~mclk;

  // collect recovered bits mid-cycle, clear of the launching edge
  always @(negedge mclk) begin
    if (pBitVal === 1'b1) pq.push_back(pBit);
    if (dBitVal === 1'b1) dq.push_back(dBit);
    if (val2 === 1'b1) q2.push_back(bit2);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // bounded wait for a level
  task automatic wt(ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 40000) begin
      @(negedge mclk);
      i++;
    end
    chk(32'(i < 40000), 1, "wait bound");
  endtask

  // wait n cycles, then flip the lone wire
  task automatic tg(input int n);
    repeat (n) @(negedge mclk);
    cc2.ptnOut = ~cc2.ptnOut;
  endtask

  task automatic dev_frame();
    logic        e[$];
    logic [31:0] c;
    logic [7:0]  b;
    int          i;
    b = 8'hA5;
    c = pdbmc_pkg::CRC_INIT;
    for (i = 0; i < 64; i++) e.push_back(i[0]);
    for (i = 0; i < 8; i++) begin
      e.push_back(b[i]);
      c = (c[0] ^ b[i]) ? (c >> 1) ^ pdbmc_pkg::CRC_POLY : c >> 1;
    end
    for (i = 0; i < 32; i++) e.push_back(~c[i]);
    @(negedge mclk);
    dValid = 1'b1;
    dData = b;
    wt(dReady, 1'b1);
    @(negedge mclk);
    dValid = 1'b0;
    wt(dBusy, 1'b0);
    repeat (20) @(negedge mclk);
    chk(32'(pq.size() >= 103), 1, "tx bit count");
    for (i = 0; i < 103 && i < pq.size(); i++) chk(pq[i], e[i], "tx bit");
  endtask

  task automatic ptn_send(input logic [7:0] b, output int g);
    @(negedge mclk);
    pValid = 1'b1;
    pData = b;
    g = 0;
    while (cc.ptnOe !== 1'b1 && g < 9000) begin
      @(negedge mclk);
      g++;
    end
    wt(pReady, 1'b1);
    @(negedge mclk);
    pValid = 1'b0;
    wt(pBusy, 1'b0);
  endtask

  task automatic ptn_frames();
    logic [8:0] w;
    int         g, n, k;
    w = {8'h1C, 1'b1};
    ptn_send(8'h07, g);
    dq.delete();
    ptn_send(8'h1C, g);
    chk(32'(g <= 4900), 1, "gap long");
    repeat (600) @(negedge mclk);
    chk(rxBusy, 0, "rx idle");
    n = dq.size();
    chk(32'(n > 9), 1, "rx count");
    for (k = 0; k < 9 && n > 9; k++) chk(dq[n-9+k], w[k], "rx bit");
  endtask

  task automatic frs_pulse();
    int n;
    @(negedge mclk);
    frsReq = 1'b1;
    @(negedge mclk);
    frsReq = 1'b0;
    n = 0;
    repeat (3) if (cc.devOe !== 1'b1) @(negedge mclk);
    chk(cc.line, 0, "swap level");
    while (cc.devOe === 1'b1 && n < 200) begin
      n++;
      @(negedge mclk);
    end
    chk(n, 32'(FRS), "swap length");
  endtask

  task automatic rx_filter();
    int         sp[6] = '{120, 150, 300, 370, 185, 185};
    logic [3:0] x;
    int         k;
    x = 4'h9;
    frs2 = 1'b1;
    for (k = 0; k < 4; k++) tg(300);
    chk({cc2.devOe, rxBusy2}, 0, "detached");
    frs2 = 1'b0;
    repeat (600) @(negedge mclk);
    att2 = 1'b1;
    for (k = 0; k < 6; k++) tg(5);
    tg(300);
    tg(300);
    repeat (50) @(negedge mclk);
    chk(rxBusy2, 0, "two edges");
    q2.delete();
    tg(250);
    repeat (30) @(negedge mclk);
    chk(rxBusy2, 1, "third edge");
    for (k = 0; k < 6; k++) tg(sp[k]);
    repeat (30) @(negedge mclk);
    chk(q2.size(), 4, "rate bits");
    for (k = 0; k < 4 && k < q2.size(); k++) chk(q2[k], x[k], "rate bit");
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    {mclk, arst_n, frsReq, att2, frs2, dValid, pValid} = '0;
    {attached, dLast, pLast} = 3'h7;
    {dData, pData} = 16'h0000;
    {bad_count, compares} = '0;
    cc2.ptnOe = 1'b1;
    cc2.ptnOut = 1'b0;
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    dev_frame();
    ptn_frames();
    frs_pulse();
    rx_filter();
    complete_run();
  end

  // hang guard
  initial begin
    #1000000;
    bad_count++;
    complete_run();
  end
endmodule // pd_bmc_line_timing_tb

// ===== test/pdbmc_cc_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// cc wire timing checks
// ----------------------------------------------------------------
module pdbmc_cc_properties #(
  parameter logic [13:0] FRS_CYC = pdbmc_pkg::FRS_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic ptnOut,
  input wire logic ptnOe,
  input wire logic line
);
  logic [15:0] dRun_ff;  // cycles since device level change
  logic [15:0] pRun_ff;  // cycles since partner level change
  logic [15:0] dOff_ff;  // cycles device released
  logic [15:0] pOff_ff;  // cycles partner released
  logic [15:0] dOn_ff;   // cycles device driving
  logic        dPrev_ff; // device level last cycle
  logic        pPrev_ff; // partner level last cycle
  logic        frs_ff;   // current drive is a swap pulse

  // saturating step, so long idles never wrap
  function automatic logic [15:0] inc(input logic [15:0] v);
    return v + {15'h0000, ~&v};
  endfunction

  // run, release and drive counters
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {dRun_ff, pRun_ff, dOff_ff, pOff_ff, dOn_ff} <= '0;
      {dPrev_ff, pPrev_ff, frs_ff} <= '0;
    end else begin
      dPrev_ff <= devOut;
      pPrev_ff <= ptnOut;
      dRun_ff  <= (devOut != dPrev_ff) ? 16'h0000 : inc(dRun_ff);
      pRun_ff  <= (ptnOut != pPrev_ff) ? 16'h0000 : inc(pRun_ff);
      dOff_ff  <= devOe ? 16'h0000 : inc(dOff_ff);
      pOff_ff  <= ptnOe ? 16'h0000 : inc(pOff_ff);
      dOn_ff   <= devOe ? inc(dOn_ff) : 16'h0000;
      frs_ff   <= (devOe && dOn_ff == 16'h0000) ? !devOut : frs_ff;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  dev_cell_a: assert property (
    devOe && $past(devOe) && devOut != dPrev_ff
    |-> dRun_ff inside {[16'h00A4:16'h00A8], [16'h014B:16'h014F]})
    else $error("device cell timing off");
  ptn_cell_a: assert property (
    ptnOe && $past(ptnOe) && ptnOut != pPrev_ff
    |-> pRun_ff inside {[16'h00A4:16'h00A8], [16'h014B:16'h014F]})
    else $error("partner cell timing off");
  dev_start_a: assert property (
    $rose(devOe) && devOut |-> devOut[*8])
    else $error("device drive start not at first edge");
  ptn_start_a: assert property (
    $rose(ptnOe) |-> ptnOut[*8])
    else $error("partner drive start not at first edge");
  dev_gap_a: assert property (
    $rose(devOe) && devOut |-> dOff_ff >= 16'h0960)
    else $error("device frame gap short");
  ptn_gap_a: assert property (
    $rose(ptnOe) |-> pOff_ff >= 16'h0960)
    else $error("partner frame gap short");
  dev_hold_a: assert property (
    $fell(devOe) && !frs_ff
    |-> !$past(devOut) && dRun_ff inside {[16'h0062:16'h08FC]})
    else $error("device tail hold wrong");
  ptn_hold_a: assert property (
    $fell(ptnOe) |-> !$past(ptnOut) && pRun_ff inside {[16'h0062:16'h08FC]})
    else $error("partner tail hold wrong");
  dev_frs_a: assert property (
    $fell(devOe) && frs_ff |-> dOn_ff == 16'(FRS_CYC) && !$past(line))
    else $error("swap pulse length wrong");

  // main scenarios seen
  cover property ($fell(devOe) && frs_ff);
  cover property ($fell(devOe) && !frs_ff);
  cover property ($fell(ptnOe));
endmodule // pdbmc_cc_properties
